// ===== verilog/file_move_swap_defs.vh
`ifndef FILE_MOVE_SWAP_DEFS_VH
`define FILE_MOVE_SWAP_DEFS_VH

// Opcode field positions and patterns for the 12-bit instruction word.
`define OP_HI_MSB 11
`define OP_HI_LSB 6
`define OP_DEST_BIT 5
`define OP_ADDR_MSB 4
`define OP_ADDR_LSB 0
`define OP_LIT_MSB 7
`define OP_LIT_LSB 0
`define OP_LIT_HI_MSB 11
`define OP_LIT_HI_LSB 8
`define PAT_FILE_MOVE 6'h08
`define PAT_NIBBLE_SWAP 6'h0e
`define PAT_LITERAL_LOAD 4'hc
`define PAT_STORE_HI 7'h01
`define PAT_IDLE 12'h000

// Operation codes handed from the decoder to the datapath.
`define OPC_W 3
`define OPC_NONE 3'h0
`define OPC_MOVE 3'h1
`define OPC_SWAP 3'h2
`define OPC_LIT 3'h3
`define OPC_STORE 3'h4
`define OPC_IDLE 3'h5

// Reset values.
`define WORK_RESET 8'h00
`define ZERO_RESET 1'b0
`define ADDR_RESET 5'h00
`define WDATA_RESET 8'h00
`define PULSE_RESET 1'b0

// Position of the high part of the store pattern.
`define OP_STORE_MSB 11
`define OP_STORE_LSB 5

`endif

// ===== verilog/op_classifier.v
`timescale 1ns/1ps
`include "file_move_swap_defs.vh"

module op_classifier (
  input wire [11:0] instr_i,
  output reg [2:0] opc_o
);

  always @* begin
    if (instr_i[`OP_HI_MSB:`OP_HI_LSB] == `PAT_FILE_MOVE) begin
      opc_o = `OPC_MOVE;
    end else if (instr_i[`OP_HI_MSB:`OP_HI_LSB] == `PAT_NIBBLE_SWAP) begin
      opc_o = `OPC_SWAP;
    end else if (instr_i[`OP_LIT_HI_MSB:`OP_LIT_HI_LSB] ==
                 `PAT_LITERAL_LOAD) begin
      opc_o = `OPC_LIT;
    end else if (instr_i[`OP_STORE_MSB:`OP_STORE_LSB] == `PAT_STORE_HI) begin
      opc_o = `OPC_STORE;
    end else if (instr_i == `PAT_IDLE) begin
      opc_o = `OPC_IDLE;
    end else begin
      opc_o = `OPC_NONE;
    end
  end

endmodule

// ===== verilog/file_move_swap_decoder.v
`timescale 1ns/1ps
`include "file_move_swap_defs.vh"


module file_move_swap_decoder (
  input wire clock_i,
  input wire rst_i,
  input wire instr_valid_i,
  input wire [11:0] instr_i,
  input wire [7:0] file_rdata_i,
  output reg [4:0] file_addr_o,
  output reg [7:0] file_wdata_o,
  output reg file_we_o,
  output reg [7:0] work_o,
  output reg zero_o,
  output reg zero_we_o,
  output reg done_o,
  output reg illegal_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  wire [2:0] opc;
  wire dest_file;
  wire [4:0] addr;
  wire [7:0] swapped;
  wire take;
  // Next values and write enables for each registered output but file_addr_o.
  wire work_we;
  wire [7:0] work_d;
  wire [7:0] file_wdata_d;
  wire file_we_d;
  wire zero_d;
  wire zero_we_d;
  wire done_d;
  wire illegal_d;
  reg [7:0] result;
  genvar bit_idx;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  // Destination and flag choices live in functions so that the write
  // enables and the flag logic read one decision and cannot drift apart.
  function writes_file;
    input [2:0] op;
    input dest;
    begin
      case (op)
        `OPC_MOVE: begin
          writes_file = dest;
        end
        `OPC_SWAP: begin
          writes_file = dest;
        end
        `OPC_STORE: begin
          writes_file = 1'b1;
        end
        default: begin
          writes_file = 1'b0;
        end
      endcase
    end
  endfunction

  function writes_work;
    input [2:0] op;
    input dest;
    begin
      case (op)
        `OPC_MOVE: begin
          writes_work = ~dest;
        end
        `OPC_SWAP: begin
          writes_work = ~dest;
        end
        `OPC_LIT: begin
          writes_work = 1'b1;
        end
        default: begin
          writes_work = 1'b0;
        end
      endcase
    end
  endfunction

  // Only a file move touches the zero flag; a swap, a literal load, a store
  // and the idle word leave it as it was.
  function touches_zero;
    input [2:0] op;
    begin
      touches_zero = (op == `OPC_MOVE);
    end
  endfunction

  // Both the retire pulse and the refusal pulse use this test.
  function is_handled;
    input [2:0] op;
    begin
      is_handled = (op != `OPC_NONE);
    end
  endfunction

  function is_zero;
    input [7:0] value;
    begin
      is_zero = (value == 8'h00);
    end
  endfunction

  // ****************************************************************
  // Instruction fields
  // ****************************************************************
  op_classifier op_classifier_inst (
    .instr_i(instr_i),
    .opc_o(opc)
  );

  assign take = instr_valid_i;
  assign dest_file = instr_i[`OP_DEST_BIT];
  assign addr = instr_i[`OP_ADDR_MSB:`OP_ADDR_LSB];

  // ****************************************************************
  // Operand paths
  // ****************************************************************
  // The file read is combinational and addressed straight from the word,
  // so the operand settles in the same cycle in which the word is taken.
  // The caller must forward a write of the previous cycle to its read port.
  generate
    for (bit_idx = 0; bit_idx < 4; bit_idx = bit_idx + 1) begin : g_swap
      assign swapped[bit_idx + 4] = file_rdata_i[bit_idx];
      assign swapped[bit_idx] = file_rdata_i[bit_idx + 4];
    end
  endgenerate

  // ****************************************************************
  // Result selection
  // ****************************************************************
  always @* begin
    result = work_o;
    case (opc)
      `OPC_MOVE: begin
        result = file_rdata_i;
      end
      `OPC_SWAP: begin
        result = swapped;
      end
      `OPC_LIT: begin
        result = instr_i[`OP_LIT_MSB:`OP_LIT_LSB];
      end
      `OPC_STORE: begin
        result = work_o;
      end
      default: begin
        result = work_o;
      end
    endcase
  end

  // ****************************************************************
  // Destination
  // ****************************************************************
  // A word that is not decoded here writes nothing, so a word meant for
  // another execution unit cannot disturb W or the file.
  assign file_we_d = take && writes_file(opc, dest_file);
  assign work_we = take && writes_work(opc, dest_file);
  assign work_d = work_we ? result : work_o;
  // The write data is only meaningful while the write pulse is high.
  assign file_wdata_d = result;

  // ****************************************************************
  // Status flag
  // ****************************************************************
  // The flag is written for either destination, which is what lets a move
  // of a register onto itself serve as a zero test of that register.
  assign zero_we_d = take && touches_zero(opc);
  assign zero_d = zero_we_d ? is_zero(result) : zero_o;

  // ****************************************************************
  // Retire
  // ****************************************************************
  // Every handled word retires in exactly one cycle; there is no stall.
  assign done_d = take && is_handled(opc);
  // A refused word pulses illegal_o; W, the zero flag and the file keep their values.
  assign illegal_d = take && !is_handled(opc);

  // ****************************************************************
  // State and outputs
  // ****************************************************************
  // Outputs come straight from flip-flops, so the fetch path and the file
  // see values that stand for the whole of the following cycle.
  always @(posedge clock_i) begin
    if (rst_i) begin
      work_o <= `WORK_RESET;
      zero_o <= `ZERO_RESET;
      zero_we_o <= `PULSE_RESET;
      file_addr_o <= `ADDR_RESET;
      file_wdata_o <= `WDATA_RESET;
      file_we_o <= `PULSE_RESET;
      done_o <= `PULSE_RESET;
      illegal_o <= `PULSE_RESET;
    end else begin
      work_o <= work_d;
      zero_o <= zero_d;
      zero_we_o <= zero_we_d;
      // The address travels with the data, so a write pulse always names
      // the register of the word that made it.
      file_addr_o <= addr;
      file_wdata_o <= file_wdata_d;
      file_we_o <= file_we_d;
      done_o <= done_d;
      illegal_o <= illegal_d;
    end
  end

endmodule

// ===== testbench/file_move_swap_decoder_assertions.sv
`timescale 1ns/1ps
module move_swap_checker(input wire clock_i, rst_i, instr_valid_i, file_we_o,
  zero_o, zero_we_o, done_o, illegal_o, input wire [11:0] instr_i,
  input wire [4:0] file_addr_o, input wire [7:0] file_rdata_i, file_wdata_o,
  work_o);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire v = instr_valid_i;
  wire d = instr_i[5];
  wire mv = v && instr_i[11:6] == 6'h08;
  wire sw = v && instr_i[11:6] == 6'h0e;
  wire lt = v && instr_i[11:8] == 4'hc;
  wire ot = lt || v && (instr_i[11:5] == 7'h01 || instr_i == 12'h000);
  wire [7:0] sv = {file_rdata_i[3:0], file_rdata_i[7:4]};
  wire [7:0] k = instr_i[7:0];
  wire st = v && instr_i[11:5] == 7'h01;
  wire un = v && !mv && !sw && !ot;
  chk_move_file: assert property (
    mv && d |=> file_we_o && file_wdata_o == $past(file_rdata_i) &&
      file_addr_o == $past(instr_i[4:0]))
    else $error("move to file wrong");
  chk_move_work: assert property (
    mv && !d |=> !file_we_o && work_o == $past(file_rdata_i))
    else $error("move to work wrong");
  chk_move_zero: assert property (
    mv |=> zero_we_o && zero_o == ($past(file_rdata_i) == 8'h00))
    else $error("zero flag wrong");
  chk_swap_value: assert property (
    sw |=> ($past(d) ? file_wdata_o : work_o) == $past(sv))
    else $error("swap value wrong");
  chk_swap_flag: assert property (
    sw |=> file_we_o == $past(d) && !zero_we_o && $stable(zero_o))
    else $error("swap target or flag wrong");
  chk_other_flag: assert property (
    ot |=> done_o && !zero_we_o && $stable(zero_o))
    else $error("flag touched or not retired");
  chk_lit_load: assert property (
    lt |=> work_o == $past(k)) else $error("literal load wrong");
  chk_store_data: assert property (
    st |=> file_we_o && file_wdata_o == $past(work_o) &&
      file_addr_o == $past(instr_i[4:0])) else $error("store wrong");
  cover property (mv && d);
  cover property (sw && !d);
  cover property (lt);
  cover property (un);
endmodule

// ===== testbench/file_move_swap_decoder_test.sv
`timescale 1ns/1ps
module file_move_swap_decoder_test;
  reg clock_i = 0, rst_i = 1, instr_valid_i = 0, z = 0, fw;
  reg [11:0] instr_i = 0;
  reg [7:0] file_rdata_i = 0, w = 0, e;
  reg [31:0] rnd;
  reg mv, dn;
  integer seed = 42996, num_errors = 0, check_count = 0, i;
  wire [4:0] fa;
  wire [7:0] wd, work_o;
  wire we, zero_o, zwe, done_o, ill;
  always #25 clock_i = ~clock_i;
  file_move_swap_decoder file_move_swap_decoder_inst(.clock_i(clock_i),
    .rst_i(rst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .file_rdata_i(file_rdata_i), .file_addr_o(fa), .file_wdata_o(wd),
    .file_we_o(we), .work_o(work_o), .zero_o(zero_o), .zero_we_o(zwe),
    .done_o(done_o), .illegal_o(ill));
  task check(input [7:0] seen, input [7:0] exp); begin
    check_count = check_count + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  end endtask
  task wrap_up; begin
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  end endtask
  function [7:0] res(input [11:0] op, input [7:0] r);
    res = op[11:6] == 6'h08 ? r : op[11:6] == 6'h0e ? {r[3:0], r[7:4]} :
      op[11:8] == 4'hc ? op[7:0] : w;
  endfunction
  function known(input [11:0] op);
    known = op[11:6] == 6'h08 || op[11:6] == 6'h0e || op[11:8] == 4'hc ||
      op[11:5] == 7'h01 || op == 12'h000;
  endfunction
  // Called just after an edge, so steps run back to back.
  task step(input [11:0] op, input [7:0] r); begin
    instr_i = op;
    instr_valid_i = 1;
    file_rdata_i = r;
    e = res(op, r);
    mv = op[11:6] == 6'h08;
    dn = known(op);
    fw = op[5] && (op[11:6] == 6'h08 || op[11:6] == 6'h0e) ||
      op[11:5] == 7'h01;
    if (!fw && op != 12'h000) w = e;
    if (mv) z = (e == 8'h00);
    @(posedge clock_i);
    #5;
    check(work_o, w);
    check(zero_o, z);
    check(we, fw);
    if (fw) check(wd, e);
    if (fw) check(fa, op[4:0]);
    check(zwe, mv);
    check(done_o, dn);
    check(ill, !dn);
  end endtask
  initial begin
    repeat (2) @(posedge clock_i);
    #5 rst_i = 0;
    step(12'hc5a, 0);
    step(12'h220, 8'h00);
    step(12'h3bf, 8'ha5);
    step(12'h03f, 8'h00);
    step(12'h000, 8'h01);
    step(12'h1c5, 8'h00);
    step(12'h01f, 8'h7e);
    step(12'h205, 8'h80);
    $display("corner test done");
    rst_i = 1;
    instr_valid_i = 0;
    repeat (2) @(posedge clock_i);
    #5;
    check(work_o, 8'h00);
    check({zero_o, zwe, we, done_o, ill}, 8'h00);
    rst_i = 0;
    w = 0;
    z = 0;
    step(12'h380, 8'h3c);
    $display("reset test done");
    for (i = 0; i < 300; i = i + 1) begin
      rnd = $random(seed);
      case (i % 7)
        0: step({6'h08, rnd[5:0]}, rnd[19:12]);
        1: step({6'h0e, rnd[5:0]}, rnd[19:12]);
        2: step({4'hc, rnd[7:0]}, rnd[19:12]);
        3: step({7'h01, rnd[4:0]}, rnd[19:12]);
        4: step({4'h1, rnd[7:0]}, rnd[19:12]);
        5: step(rnd[11:0], rnd[19:12]);
        default: step(12'h000, rnd[19:12]);
      endcase
    end
    $display("random test done");
    wrap_up;
  end
endmodule
bind file_move_swap_decoder move_swap_checker move_swap_checker_inst(
  .clock_i(clock_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
  .file_we_o(file_we_o), .zero_o(zero_o), .zero_we_o(zero_we_o),
  .done_o(done_o), .illegal_o(illegal_o), .instr_i(instr_i),
  .file_addr_o(file_addr_o), .file_rdata_i(file_rdata_i),
  .file_wdata_o(file_wdata_o), .work_o(work_o));
